// *** core/hcof_regs.sv ***
// Purpose: Capability offset registers: doorbell offset, runtime space
//          offset, second capability word, with the logic they steer.
// Assumes: One clock, active-low async reset, synchronous inputs.
// Notes:   Read data appear one cycle after the read strobe.
`timescale 1ns/1ps
`include "hcof_cfg.svh"

module hcof_regs
  import hcof_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RSTN,
  input wire logic CLK_EN,
  input wire logic [7:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  input wire logic [4*`HCOF_NPORT-1:0] PORT_LINK_STATE,
  input wire logic [`HCOF_NPORT-1:0] LINK_FLAG_CLR,
  output logic [`HCOF_NPORT-1:0] LINK_CHANGE_FLAG,
  input wire logic CFG_EP_REQ,
  input wire logic CFG_EP_LAT_EXCEEDED,
  output logic CFG_EP_DONE,
  output logic CFG_EP_LAT_ERR,
  input wire logic SAVE_REQ,
  output logic CTX_WR_VALID,
  output logic [1:0] CTX_WR_INDEX,
  input wire logic CTX_WR_READY,
  output logic SAVE_DONE
);

  // ==========================================================
  // Fixed register values
  // doorbell and runtime offset alignment
  localparam logic [31:0] DB_VALUE = hcof_align(`HCOF_DB_BYTE_OFF,
    `HCOF_VIRT_SUPPORT, `HCOF_PAGE_SHIFT, `HCOF_DB_BASE_SHIFT);
  localparam logic [31:0] RTS_VALUE = hcof_align(`HCOF_RTS_BYTE_OFF,
    `HCOF_VIRT_SUPPORT, `HCOF_PAGE_SHIFT, `HCOF_RTS_BASE_SHIFT);
  // Capability flags, each fixed at build time
  localparam logic CAP_SUSP = `HCOF_SUSP_NOTIFY_DEFAULT; // Suspend notify
  localparam logic CAP_LAT_ERR = `HCOF_LAT_ERR_DEFAULT; // Latency error
  localparam logic CAP_FORCE_SAVE = `HCOF_FORCE_SAVE_DEFAULT; // Forced save
  localparam logic [31:0] CAP2_VALUE = {29'h0000_0000, CAP_FORCE_SAVE,
    CAP_LAT_ERR, CAP_SUSP};

  // ==========================================================
  // Address decode helper
  // Shared by the read mux and the write path
  function automatic logic addr_hit(
    input logic [7:0] addr,
    input logic [7:0] off
  );
    return addr == off;
  endfunction

  // ==========================================================
  // Declarations
  logic [31:0] rdata_reg; // Registered read data
  logic [31:0] rdata_next; // Read mux output
  logic lat_en_reg; // Software enable for latency error
  logic ep_done_reg; // Endpoint command done pulse
  logic ep_err_reg; // Endpoint command error beside done
  logic ep_err_next; // Error decision this cycle
  hcof_save_e save_reg; // Save-state walker state
  hcof_save_e save_next; // Next walker state
  logic [1:0] ctx_idx_reg; // Context being written back
  logic [1:0] ctx_idx_next; // Next context index
  logic save_busy; // Walker not idle
  logic [`HCOF_NPORT-1:0] link_flags; // Flags from watchers

  // ==========================================================
  // Link-state watchers, one per root port
  genvar gp;
  generate
    for (gp = 0; gp < `HCOF_NPORT; gp++) begin : g_port
      hcof_u3_watch u_watch (
        .clk(SYS_CLK),
        .rstn(RSTN),
        .ce(CLK_EN),
        .cap_en(CAP2_VALUE[`HCOF_SUSP_NOTIFY_BIT]),
        .link_state(PORT_LINK_STATE[4*gp +: 4]),
        .clr(LINK_FLAG_CLR[gp]),
        .flag(link_flags[gp])
      );
    end
  endgenerate

  assign LINK_CHANGE_FLAG = link_flags;

  // ==========================================================
  // Local control register
  // Only the enable bit is writable; the capability words are not
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      lat_en_reg <= 1'h0;
    end else if (CLK_EN) begin
      if (REG_WR && addr_hit(REG_ADDR, `HCOF_LCTRL_ADDR)) begin
        lat_en_reg <= REG_WDATA[`HCOF_LCTRL_ELE_BIT];
      end
    end
  end

  // ==========================================================
  // Read mux
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (addr_hit(REG_ADDR, `HCOF_DB_OFF_ADDR)) begin
      rdata_next = DB_VALUE;
    end else if (addr_hit(REG_ADDR, `HCOF_RTS_OFF_ADDR)) begin
      rdata_next = RTS_VALUE;
    end else if (addr_hit(REG_ADDR, `HCOF_CAP2_ADDR)) begin
      rdata_next = CAP2_VALUE;
    end else if (addr_hit(REG_ADDR, `HCOF_LCTRL_ADDR)) begin
      // Enable bit reads back
      rdata_next[`HCOF_LCTRL_ELE_BIT] = lat_en_reg;
    end else if (addr_hit(REG_ADDR, `HCOF_LSTAT_ADDR)) begin
      // Live port flags and walker busy
      rdata_next[`HCOF_NPORT-1:0] = link_flags;
      rdata_next[`HCOF_LSTAT_BUSY_BIT] = save_busy;
    end
  end

  // Read data register: valid only in the cycle after the strobe
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      rdata_reg <= 32'h0000_0000;
    end else if (CLK_EN) begin
      if (REG_RD) begin
        rdata_reg <= rdata_next;
      end else begin
        rdata_reg <= 32'h0000_0000;
      end
    end
  end

  assign REG_RDATA = rdata_reg;

  // ==========================================================
  // Endpoint configuration answer
  // Latency judgement is made by the command engine; this only gates
  // whether its verdict may turn into an error completion.
  always_comb begin
    ep_err_next = CFG_EP_REQ && CFG_EP_LAT_EXCEEDED &&
                  CAP2_VALUE[`HCOF_LAT_ERR_BIT] && lat_en_reg;
  end

  // Done pulse and error flag, one cycle after the request
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ep_done_reg <= 1'h0;
      ep_err_reg <= 1'h0;
    end else if (CLK_EN) begin
      ep_done_reg <= CFG_EP_REQ;
      ep_err_reg <= ep_err_next;
    end
  end

  assign CFG_EP_DONE = ep_done_reg;
  assign CFG_EP_LAT_ERR = ep_err_reg;

  // ==========================================================
  // Save-state walker
  // Without forced save there is nothing to flush, so the request is
  // answered at once; with it every cached context goes out first.
  always_comb begin
    save_next = save_reg;
    ctx_idx_next = ctx_idx_reg;
    unique case (save_reg)
      HCOF_SAVE_IDLE: begin
        // Wait for a save request
        if (SAVE_REQ) begin
          if (CAP2_VALUE[`HCOF_FORCE_SAVE_BIT]) begin
            save_next = HCOF_SAVE_WRITE;
            ctx_idx_next = 2'h0;
          end else begin
            save_next = HCOF_SAVE_DONE;
          end
        end
      end
      HCOF_SAVE_WRITE: begin
        // One context per accepted beat
        if (CTX_WR_READY) begin
          if (ctx_idx_reg == `HCOF_CTX_LAST) begin
            save_next = HCOF_SAVE_DONE;
          end else begin
            ctx_idx_next = ctx_idx_reg + 2'h1;
          end
        end
      end
      HCOF_SAVE_DONE: begin
        // Single-cycle completion
        save_next = HCOF_SAVE_IDLE;
      end
      default: begin
        // Illegal code recovers to idle
        save_next = HCOF_SAVE_IDLE;
      end
    endcase
  end

  // Walker state and index registers
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      save_reg <= HCOF_SAVE_IDLE;
      ctx_idx_reg <= 2'h0;
    end else if (CLK_EN) begin
      save_reg <= save_next;
      ctx_idx_reg <= ctx_idx_next;
    end
  end

  assign save_busy = save_reg != HCOF_SAVE_IDLE;
  assign CTX_WR_VALID = save_reg == HCOF_SAVE_WRITE;
  assign CTX_WR_INDEX = ctx_idx_reg;
  assign SAVE_DONE = save_reg == HCOF_SAVE_DONE;

  // ==========================================================
  // Checks
  a_db_read_value: assert property (
    @(posedge SYS_CLK) disable iff (!RSTN)
    (CLK_EN && REG_RD && REG_ADDR == `HCOF_DB_OFF_ADDR)
    |=> REG_RDATA == DB_VALUE)
    else $error("doorbell offset read wrong");

  a_db_low_bits: assert property (
    @(posedge SYS_CLK) disable iff (!RSTN)
    (CLK_EN && REG_RD && REG_ADDR == `HCOF_DB_OFF_ADDR)
    |=> REG_RDATA[1:0] == 2'h0 &&
        REG_RDATA[31:2] == `HCOF_DB_BYTE_OFF >> 2)
    else $error("doorbell dword field or reserved bits wrong");

  a_db_boundary: assert property (
    @(posedge SYS_CLK) disable iff (!RSTN)
    (CLK_EN && REG_RD && REG_ADDR == `HCOF_DB_OFF_ADDR)
    |=> (REG_RDATA & ((32'h1 << (`HCOF_VIRT_SUPPORT ?
         `HCOF_PAGE_SHIFT : `HCOF_DB_BASE_SHIFT)) - 32'h1)) == 32'h0)
    else $error("doorbell array misaligned");

  a_rts_read_value: assert property (
    @(posedge SYS_CLK) disable iff (!RSTN)
    (CLK_EN && REG_RD && REG_ADDR == `HCOF_RTS_OFF_ADDR)
    |=> REG_RDATA == RTS_VALUE)
    else $error("runtime offset read wrong");

  a_rts_units: assert property (
    @(posedge SYS_CLK) disable iff (!RSTN)
    (CLK_EN && REG_RD && REG_ADDR == `HCOF_RTS_OFF_ADDR)
    |=> REG_RDATA[4:0] == 5'h00 &&
        REG_RDATA[31:5] == `HCOF_RTS_BYTE_OFF >> 5)
    else $error("runtime unit field or reserved bits wrong");

  a_rts_boundary: assert property (
    @(posedge SYS_CLK) disable iff (!RSTN)
    (CLK_EN && REG_RD && REG_ADDR == `HCOF_RTS_OFF_ADDR)
    |=> (REG_RDATA & ((32'h1 << (`HCOF_VIRT_SUPPORT ?
         `HCOF_PAGE_SHIFT : `HCOF_RTS_BASE_SHIFT)) - 32'h1)) == 32'h0)
    else $error("runtime block misaligned");

  a_cap2_value: assert property (
    @(posedge SYS_CLK) disable iff (!RSTN)
    (CLK_EN && REG_RD && REG_ADDR == `HCOF_CAP2_ADDR)
    |=> REG_RDATA[31:3] == 29'h0 && REG_RDATA[2:0] ==
        {`HCOF_FORCE_SAVE_DEFAULT, `HCOF_LAT_ERR_DEFAULT,
         `HCOF_SUSP_NOTIFY_DEFAULT})
    else $error("capability word read wrong");

  a_lat_err_gate: assert property (
    @(posedge SYS_CLK) disable iff (!RSTN)
    (CLK_EN && CFG_EP_REQ && !CAP_LAT_ERR)
    |=> CFG_EP_DONE && !CFG_EP_LAT_ERR)
    else $error("latency error without capability");

  a_lat_err_enable: assert property (
    @(posedge SYS_CLK) disable iff (!RSTN)
    (CLK_EN && CFG_EP_REQ)
    |=> CFG_EP_LAT_ERR == ($past(lat_en_reg) && CAP_LAT_ERR &&
        $past(CFG_EP_LAT_EXCEEDED)))
    else $error("latency error ignores enable flag");

  a_save_flush: assert property (
    @(posedge SYS_CLK) disable iff (!RSTN)
    (CLK_EN && SAVE_REQ && !save_busy)
    |=> (CAP_FORCE_SAVE ? (CTX_WR_VALID && CTX_WR_INDEX == 2'h0) : SAVE_DONE))
    else $error("save state did not start correctly");

  a_write_ignored: assert property (
    @(posedge SYS_CLK) disable iff (!RSTN)
    (CLK_EN && REG_WR) |=> REG_RDATA == 32'h0 ##0
    (CLK_EN && REG_RD && REG_ADDR == `HCOF_DB_OFF_ADDR)[*1]
    |=> REG_RDATA == DB_VALUE)
    else $error("write disturbed fixed register");

  // Read data must not linger, or software could see a stale word
  a_rdata_idle: assert property (
    @(posedge SYS_CLK) disable iff (!RSTN)
    (CLK_EN && !REG_RD) |=> REG_RDATA == 32'h0000_0000)
    else $error("read data not cleared outside a read");

  a_ep_no_req: assert property (
    @(posedge SYS_CLK) disable iff (!RSTN)
    (CLK_EN && !CFG_EP_REQ) |=> !CFG_EP_DONE && !CFG_EP_LAT_ERR)
    else $error("endpoint answer without a request");

  a_ctx_hold: assert property (
    @(posedge SYS_CLK) disable iff (!RSTN)
    (CLK_EN && CTX_WR_VALID && !CTX_WR_READY)
    |=> CTX_WR_VALID && $stable(CTX_WR_INDEX))
    else $error("context write changed before acceptance");

  a_save_last_beat: assert property (
    @(posedge SYS_CLK) disable iff (!RSTN)
    (CLK_EN && CTX_WR_VALID && CTX_WR_READY &&
     CTX_WR_INDEX == `HCOF_CTX_LAST) |=> SAVE_DONE && !CTX_WR_VALID)
    else $error("save did not finish after the last context");

  a_save_done_once: assert property (
    @(posedge SYS_CLK) disable iff (!RSTN)
    (CLK_EN && SAVE_DONE) |=> !save_busy)
    else $error("walker stayed busy after completion");

endmodule // hcof_regs

// *** core/hcof_cfg.svh ***
// Purpose: Fixed values, offsets and field positions of the capability
//          offset register bank.
// Assumes: Byte addresses on an 8-bit register port.
// Notes:   Offset and flag values are per-build choices; edit here only.
`ifndef HCOF_CFG_SVH
`define HCOF_CFG_SVH

// ==========================================================
// Register byte addresses
`define HCOF_DB_OFF_ADDR 8'h14
`define HCOF_RTS_OFF_ADDR 8'h18
`define HCOF_CAP2_ADDR 8'h1C
`define HCOF_LCTRL_ADDR 8'h40
`define HCOF_LSTAT_ADDR 8'h44

// ==========================================================
// Fixed offsets, in bytes from the capability base
`define HCOF_DB_BYTE_OFF 32'h0000_3000
`define HCOF_RTS_BYTE_OFF 32'h0000_1000
// Natural alignment: dword for doorbells, 32 bytes for runtime
`define HCOF_DB_BASE_SHIFT 5'h02
`define HCOF_RTS_BASE_SHIFT 5'h05
// Virtualization support and configured page size (4K)
`define HCOF_VIRT_SUPPORT 1'h0
`define HCOF_PAGE_SHIFT 5'h0C

// ==========================================================
// Second capability word flags
`define HCOF_SUSP_NOTIFY_BIT 0
`define HCOF_LAT_ERR_BIT 1
`define HCOF_FORCE_SAVE_BIT 2
`define HCOF_SUSP_NOTIFY_DEFAULT 1'h1
`define HCOF_LAT_ERR_DEFAULT 1'h1
`define HCOF_FORCE_SAVE_DEFAULT 1'h1

// ==========================================================
// Ports, link states, contexts, local register fields
`define HCOF_NPORT 4
`define HCOF_LINK_U3 4'h3
`define HCOF_LINK_RESET 4'h0
`define HCOF_CTX_LAST 2'h3
`define HCOF_LCTRL_ELE_BIT 0
`define HCOF_LSTAT_BUSY_BIT 4

`endif

// *** core/hcof_pkg.sv ***
// Purpose: Types and shared helper of the capability offset bank.
// Assumes: Nothing beyond SystemVerilog.
// Notes:   Constants live in hcof_cfg.svh.
package hcof_pkg;

  // ==========================================================
  // Types
  // Save-state walker states
  typedef enum logic [1:0] {
    HCOF_SAVE_IDLE,
    HCOF_SAVE_WRITE,
    HCOF_SAVE_DONE
  } hcof_save_e;

  // Port link state code
  typedef logic [3:0] hcof_link_t;

  // ==========================================================
  // Clears low bits so an offset sits on its required boundary
  function automatic logic [31:0] hcof_align(
    input logic [31:0] off,
    input logic virt,
    input logic [4:0] page_sh,
    input logic [4:0] base_sh
  );
    logic [4:0] sh;
    sh = virt ? page_sh : base_sh;
    return off & ~((32'h0000_0001 << sh) - 32'h0000_0001);
  endfunction

endpackage

// *** core/hcof_u3_watch.sv ***
// Purpose: Per-port watcher that raises the link-state-change flag on
//          entry into U3.
// Assumes: Link state is synchronous to the clock.
// Notes:   A set in the same cycle as a clear wins.
`timescale 1ns/1ps
`include "hcof_cfg.svh"

module hcof_u3_watch
  import hcof_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic cap_en,
  input wire hcof_link_t link_state,
  input wire logic clr,
  output logic flag
);

  // ==========================================================
  // State
  hcof_link_t prev_reg; // Link state seen last cycle
  logic flag_reg; // Sticky change flag
  logic set_now; // Entry into U3 this cycle

  // Entry is a change into U3 from any other state
  assign set_now = cap_en && (link_state == `HCOF_LINK_U3) &&
                   (prev_reg != `HCOF_LINK_U3);

  // Track previous link state
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prev_reg <= `HCOF_LINK_RESET;
    end else if (ce) begin
      prev_reg <= link_state;
    end
  end

  // Sticky flag; set beats clear so no entry is lost
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flag_reg <= 1'h0;
    end else if (ce) begin
      flag_reg <= set_now | (flag_reg & ~clr);
    end
  end

  assign flag = flag_reg;

  // ==========================================================
  // Checks
  a_u3_entry_flag: assert property (
    @(posedge clk) disable iff (!rstn)
    (ce && cap_en && link_state == `HCOF_LINK_U3 && prev_reg != `HCOF_LINK_U3)
    |=> flag)
    else $error("link change flag missed on U3 entry");

  a_u3_no_cap: assert property (
    @(posedge clk) disable iff (!rstn)
    (ce && !cap_en && !flag) |=> !flag)
    else $error("link change flag set with capability off");

  a_flag_clear: assert property (
    @(posedge clk) disable iff (!rstn)
    (ce && clr && !set_now) |=> !flag)
    else $error("link change flag survived its clear");

endmodule // hcof_u3_watch

// *** verif/hcof_regs_tb.sv ***
// Purpose: Self-checking bench for the capability offset register bank.
// Assumes: Build values in hcof_cfg.svh; one 50 MHz clock.
// Notes:   Random stimulus from a fixed seed; corner cases written out.
`timescale 1ns/1ps
`include "hcof_cfg.svh"

module hcof_regs_tb
  import hcof_pkg::*;
;
  // ==========================================================
  // Signals
  logic SYS_CLK = 1'h0; // Bench clock
  logic RSTN = 1'h0; // Held low at start
  logic CLK_EN = 1'h1; // Run enable
  logic [7:0] REG_ADDR = 8'h00;
  logic [31:0] REG_WDATA = 32'h0000_0000;
  logic REG_WR = 1'h0;
  logic REG_RD = 1'h0;
  logic [31:0] REG_RDATA;
  logic [15:0] PORT_LINK_STATE = 16'h0000; // All ports start out of U3
  logic [3:0] LINK_FLAG_CLR = 4'h0;
  logic [3:0] LINK_CHANGE_FLAG;
  logic CFG_EP_REQ = 1'h0;
  logic CFG_EP_LAT_EXCEEDED = 1'h0;
  logic CFG_EP_DONE;
  logic CFG_EP_LAT_ERR;
  logic SAVE_REQ = 1'h0;
  logic CTX_WR_VALID;
  logic [1:0] CTX_WR_INDEX;
  logic CTX_WR_READY = 1'h0;
  logic SAVE_DONE;
  int errors = 0; // Mismatch count
  int num_checks = 0; // Comparison count
  logic [31:0] rd; // Last read word
  logic [15:0] prev_link = 16'h0000; // Model of sampled link history
  logic [3:0] exp_flag = 4'h0; // Model of sticky flags

  // Design under test
  hcof_regs uut (
    .SYS_CLK(SYS_CLK), .RSTN(RSTN), .CLK_EN(CLK_EN),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .PORT_LINK_STATE(PORT_LINK_STATE), .LINK_FLAG_CLR(LINK_FLAG_CLR),
    .LINK_CHANGE_FLAG(LINK_CHANGE_FLAG), .CFG_EP_REQ(CFG_EP_REQ),
    .CFG_EP_LAT_EXCEEDED(CFG_EP_LAT_EXCEEDED), .CFG_EP_DONE(CFG_EP_DONE),
    .CFG_EP_LAT_ERR(CFG_EP_LAT_ERR), .SAVE_REQ(SAVE_REQ),
    .CTX_WR_VALID(CTX_WR_VALID), .CTX_WR_INDEX(CTX_WR_INDEX),
    .CTX_WR_READY(CTX_WR_READY), .SAVE_DONE(SAVE_DONE)
  );

  // Free-running clock, 20 ns period
  always #10 SYS_CLK = ~SYS_CLK;

  // ==========================================================
  // Expectations
  // Clears low bits; kept apart from the design's own helper
  function automatic logic [31:0] aligned(input logic [31:0] off,
                                          input int sh);
    return (off >> sh) << sh;
  endfunction
  function automatic int align_sh(input int natural_sh);
    return (`HCOF_VIRT_SUPPORT == 1'h1) ? `HCOF_PAGE_SHIFT : natural_sh;
  endfunction

  // ==========================================================
  // Compare and bus tasks
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge SYS_CLK);
    REG_WR <= 1'h1;
    REG_ADDR <= a;
    REG_WDATA <= d;
    @(posedge SYS_CLK);
    REG_WR <= 1'h0;
  endtask
  // Read strobe, then data taken in the following cycle only
  task automatic rd_word(input logic [7:0] a);
    @(posedge SYS_CLK);
    REG_RD <= 1'h1;
    REG_ADDR <= a;
    @(posedge SYS_CLK);
    REG_RD <= 1'h0;
    @(negedge SYS_CLK);
    rd = REG_RDATA;
  endtask
  // Endpoint completion with the verdict; checks pulse and error
  task automatic ep_req(input logic exc, input logic en);
    @(posedge SYS_CLK);
    CFG_EP_REQ <= 1'h1;
    CFG_EP_LAT_EXCEEDED <= exc;
    @(posedge SYS_CLK);
    CFG_EP_REQ <= 1'h0;
    @(negedge SYS_CLK);
    chk_bit(CFG_EP_DONE, 1'h1);
    chk_bit(CFG_EP_LAT_ERR, exc & en & `HCOF_LAT_ERR_DEFAULT);
    @(negedge SYS_CLK);
    chk_bit(CFG_EP_DONE, 1'h0);
    chk_bit(CFG_EP_LAT_ERR, 1'h0);
  endtask
  // Save walk with random consumer stalls and a refused retry
  task automatic save_walk();
    int beat;
    beat = 0;
    @(posedge SYS_CLK);
    SAVE_REQ <= 1'h1;
    @(posedge SYS_CLK);
    SAVE_REQ <= 1'h0;
    CTX_WR_READY <= 1'($urandom % 2);
    for (int it = 0; it < 80; it++) begin
      @(negedge SYS_CLK);
      if (beat == 4) begin
        chk_bit(SAVE_DONE, 1'h1);
        chk_bit(CTX_WR_VALID, 1'h0);
        break;
      end
      chk_bit(CTX_WR_VALID, 1'h1);
      chk_word({30'h0, CTX_WR_INDEX}, beat);
      if (CTX_WR_READY === 1'h1) beat++;
      @(posedge SYS_CLK);
      CTX_WR_READY <= 1'($urandom % 2);
      // Busy walker ignores a second request
      SAVE_REQ <= (it == 2);
    end
    chk_word(beat, 4);
    @(posedge SYS_CLK);
    CTX_WR_READY <= 1'h0;
    SAVE_REQ <= 1'h0;
    @(negedge SYS_CLK);
    chk_bit(SAVE_DONE, 1'h0);
    chk_bit(CTX_WR_VALID, 1'h0);
  endtask

  // ==========================================================
  // Verdict, used by the main sequence and the watchdog
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Watchdog: the tests need a few thousand cycles at most
  initial begin
    #(20 * 50000);
    errors++;
    complete_run();
  end

  // ==========================================================
  // Main sequence
  initial begin
    logic [7:0] ro_addr [3];
    logic [31:0] ro_exp [3];
    logic [3:0] p [4];
    logic [3:0] c;
    ro_addr = '{`HCOF_DB_OFF_ADDR, `HCOF_RTS_OFF_ADDR, `HCOF_CAP2_ADDR};
    ro_exp[0] = aligned(`HCOF_DB_BYTE_OFF, align_sh(2));
    ro_exp[1] = aligned(`HCOF_RTS_BYTE_OFF, align_sh(5));
    ro_exp[2] = {29'h0, `HCOF_FORCE_SAVE_DEFAULT, `HCOF_LAT_ERR_DEFAULT,
                 `HCOF_SUSP_NOTIFY_DEFAULT};
    void'($urandom(65));
    repeat (12) @(posedge SYS_CLK);
    RSTN <= 1'h1;
    // Fixed values, aligned, reserved bits clear, writes ignored
    for (int i = 0; i < 3; i++) begin
      rd_word(ro_addr[i]);
      chk_word(rd, ro_exp[i]);
      wr(ro_addr[i], $urandom);
      rd_word(ro_addr[i]);
      chk_word(rd, ro_exp[i]);
    end
    rd_word(`HCOF_DB_OFF_ADDR);
    chk_word(rd & 32'h0000_0003, 32'h0);
    rd_word(`HCOF_RTS_OFF_ADDR);
    chk_word(rd & 32'h0000_001F, 32'h0);
    @(negedge SYS_CLK);
    chk_word(REG_RDATA, 32'h0);
    // Unmapped reads return zero
    rd_word(8'h80 | 8'($urandom % 128));
    chk_word(rd, 32'h0);
    // Exit-latency error only with the enable set
    rd_word(`HCOF_LCTRL_ADDR);
    chk_bit(rd[0], 1'h0);
    ep_req(1'h1, 1'h0);
    wr(`HCOF_LCTRL_ADDR, 32'h0000_0001);
    rd_word(`HCOF_LCTRL_ADDR);
    chk_bit(rd[0], 1'h1);
    repeat (6) ep_req(1'($urandom % 2), 1'h1);
    // Frozen clock enable takes no request
    @(posedge SYS_CLK);
    CLK_EN <= 1'h0;
    CFG_EP_REQ <= 1'h1;
    @(posedge SYS_CLK);
    CFG_EP_REQ <= 1'h0;
    CLK_EN <= 1'h1;
    @(negedge SYS_CLK);
    chk_bit(CFG_EP_DONE, 1'h0);
    chk_bit(CFG_EP_LAT_ERR, 1'h0);
    // Random link states against the sticky flag model
    for (int n = 0; n < 4; n++) p[n] = 4'h0;
    c = 4'h0;
    repeat (200) begin
      @(posedge SYS_CLK);
      for (int n = 0; n < 4; n++) begin
        exp_flag[n] = ((p[n] == `HCOF_LINK_U3) &&
                       (prev_link[4*n+:4] != `HCOF_LINK_U3)) ||
                      (exp_flag[n] && !c[n]);
        prev_link[4*n+:4] = p[n];
        p[n] = 4'($urandom_range(0, 4));
      end
      c = 4'(($urandom % 4 == 0) ? $urandom : 0);
      PORT_LINK_STATE <= {p[3], p[2], p[1], p[0]};
      LINK_FLAG_CLR <= c;
      @(negedge SYS_CLK);
      chk_word({28'h0, LINK_CHANGE_FLAG}, {28'h0, exp_flag});
    end
    @(posedge SYS_CLK);
    for (int n = 0; n < 4; n++) begin
      exp_flag[n] = ((p[n] == `HCOF_LINK_U3) &&
                     (prev_link[4*n+:4] != `HCOF_LINK_U3)) ||
                    (exp_flag[n] && !c[n]);
    end
    LINK_FLAG_CLR <= 4'h0;
    rd_word(`HCOF_LSTAT_ADDR);
    chk_word({27'h0, rd[4:0]}, {28'h0, exp_flag});
    // Two save walks with consumer stalls
    repeat (2) save_walk();
    rd_word(`HCOF_LSTAT_ADDR);
    chk_bit(rd[4], 1'h0);
    complete_run();
  end
endmodule // hcof_regs_tb
